//--- hdl/fcp_pkg.sv
// Purpose: Shared constants for the flash command and protection block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Byte addresses below are the APB offsets

package fcp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PARAM_INDEX = 8'h00;
  localparam logic [7:0] ADDR_PARAM_DATA  = 8'h04;
  localparam logic [7:0] ADDR_STATUS      = 8'h08;
  localparam logic [7:0] ADDR_CONFIG      = 8'h0C;
  localparam logic [7:0] ADDR_SECURITY    = 8'h10;
  localparam logic [7:0] ADDR_PROTECTION  = 8'h14;
  localparam logic [7:0] ADDR_CLOCK_DIV   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_CCF_BIT   = 7;
  localparam int STAT_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int STAT_PVIOL_BIT = 4;
  localparam int CFG_CMD_COMPLETE_IRQ_EN_BIT   = 7;
  localparam int PROT_OPEN_BIT  = 7;
  localparam int PROT_HDIS_BIT  = 5;
  localparam int PROT_SIZE_HI   = 4;
  localparam int PROT_SIZE_LO   = 3;
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_VALUE_HI   = 5;

  // ----------------------------------------------------------------
  // Parameter array
  // ----------------------------------------------------------------
  localparam int          PARAM_WORDS    = 6;
  localparam logic [2:0]  IDX_CMD_ADDRHI = 3'h0;
  localparam logic [2:0]  IDX_ADDR_LO    = 3'h1;
  localparam logic [2:0]  IDX_LAST       = 3'h5;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_FIRST_LO   = 8'h01;
  localparam logic [7:0] CMD_LAST_LO    = 8'h04;
  localparam logic [7:0] CMD_FIRST_HI   = 8'h06;
  localparam logic [7:0] CMD_LAST_HI    = 8'h0E;
  localparam logic [7:0] CMD_PROGRAM    = 8'h06;
  localparam logic [7:0] CMD_PROG_ONCE  = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLK  = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECT = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE   = 8'h0B;

  // ----------------------------------------------------------------
  // Protection scenarios {open, high disable} and high region starts
  // ----------------------------------------------------------------
  localparam logic [1:0]  SCN_UNPROT_HIGH = 2'h0; // scenario 1
  localparam logic [1:0]  SCN_FULL        = 2'h1; // scenario 3
  localparam logic [1:0]  SCN_PROT_HIGH   = 2'h2; // scenario 5
  localparam logic [1:0]  SCN_NONE        = 2'h3; // scenario 7
  localparam logic [15:0] HIGH_START_2K   = 16'hF800;
  localparam logic [15:0] HIGH_START_4K   = 16'hF000;
  localparam logic [15:0] HIGH_START_8K   = 16'hE000;
  localparam logic [15:0] HIGH_START_16K  = 16'hC000;
  localparam logic [15:0] FLASH_START     = 16'hC000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [1:0] SEC_RESET  = 2'h0;

endpackage

//--- hdl/fcp_prot_check.sv
// Purpose: Decode protection bits into region hits for one address
// Assumes: Address is the low 16 bits of the global flash address
// Notes:   Pure combinational

`timescale 1ns/1ps

module fcp_prot_check
(
  input  wire logic        open_i,
  input  wire logic        hdis_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [15:0] addr_i,
  output logic             addr_protected_o,
  output logic             any_protected_o
);

  logic [15:0] high_start;
  logic        in_high;
  logic        in_low;

  // ----------------------------------------------------------------
  // High region start from size field
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (size_i)
      2'b00:   high_start = fcp_pkg::HIGH_START_2K;  // [R15]
      2'b01:   high_start = fcp_pkg::HIGH_START_4K;  // [R15]
      2'b10:   high_start = fcp_pkg::HIGH_START_8K;  // [R15]
      default: high_start = fcp_pkg::HIGH_START_16K; // [R15]
    endcase
  end

  assign in_high = (addr_i >= high_start); // [R7]
  assign in_low  = (addr_i >= fcp_pkg::FLASH_START) && !in_high; // [R7]

  // ----------------------------------------------------------------
  // Region protection per open/high-disable combination
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case ({open_i, hdis_i})
      fcp_pkg::SCN_NONE:        addr_protected_o = 1'b0;    // [R11]
      fcp_pkg::SCN_PROT_HIGH:   addr_protected_o = in_high; // [R11]
      fcp_pkg::SCN_FULL:        addr_protected_o = 1'b1;    // [R11]
      default:                  addr_protected_o = in_low;  // [R11]
    endcase
  end

  assign any_protected_o = !(open_i && hdis_i); // [R11]

endmodule // fcp_prot_check

//--- hdl/fcp_top.sv
// Purpose: Command launch front end and protection of a flash controller
// Assumes: APB slave, zero wait states; flash config bytes on ports
// Notes:   Program and erase algorithms live in the memory controller
//
// How it works
// [R1] Array index 0: command and address 23:16; 1: address 15:0; 2-5 data.
// [R2] Writing 1 to complete flag clears it and launches array to controller.
// [R3] Flag stays clear until controller done; results stay in the array.
// [R4] Codes 01-04 and 06-0E accepted whether secured or not.
// [R5] Security state comes from the security field of the security register.
// [R6] Interrupt request is complete flag AND its enable; CPU masks globally.
// [R7] Higher region grows down from FFFF; lower region covers the rest.
// [R8] Protection register loaded from the protection config byte at reset.
// [R9] Config field: key FF70-77, reserved, protection, option FF7E, security FF7F.
// [R10] Software programs FF78-FF7F as one phrase, reserved bytes as FF.
// [R11] Open/high-disable: 11 none, 10 high, 01 all, 00 all but high.
// [R12] Software may rewrite the protection register after reset.
// [R13] Writes asking a disallowed scenario change are ignored.
// [R14] Allowed: 1 to 1,3; 3 to 3; 5 to 3,5; 7 to any.
// [R15] Size field: 2, 4, 8 or 16 KB high range ending at FFFF.
// [R16] Array and index writes ignored while the complete flag is 0.
// [R17] Indices 6 and 7 ignore writes and read as zero.
// [R18] Program or erase with divider never written sets access error.
// [R19] Unknown command code sets access error, flag stays 1.
// [R20] Program/erase into protected area sets violation, memory untouched.

`timescale 1ns/1ps

module fcp_top
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [7:0]  cfg_prot_byte_i,
  input  wire logic [7:0]  cfg_sec_byte_i,
  input  wire logic        cmd_done_i,
  input  wire logic        res_we_i,
  input  wire logic [2:0]  res_index_i,
  input  wire logic [15:0] res_data_i,
  output logic             cmd_launch_o,
  output logic [7:0]       cmd_code_o,
  output logic [23:0]      cmd_addr_o,
  output logic [63:0]      cmd_data_o,
  output logic             secured_o,
  output logic [5:0]       clk_div_o,
  output logic             irq_o
);

  typedef enum logic [2:0]
  {
    FCP_INIT = 3'b001,
    FCP_IDLE = 3'b010,
    FCP_BUSY = 3'b100
  } fcp_state_e;

  fcp_state_e  state_q;
  logic [15:0] param_q [fcp_pkg::PARAM_WORDS];
  logic [2:0]  index_q;
  logic        ccf;
  logic        access_error_flag_q;
  logic        pviol_q;
  logic        cmd_complete_irq_en_q;
  logic [1:0]  sec_q;
  logic        open_q;
  logic        hdis_q;
  logic [1:0]  size_q;
  logic [5:0]  div_q;
  logic        div_loaded_q;
  logic        launch_q;
  logic [31:0] rdata_q;
  logic        slverr_q;

  logic        setup;
  logic        wr;
  logic        hit;
  logic        launch_req;
  logic        cmd_valid;
  logic        cmd_prog_erase;
  logic        cmd_whole;
  logic        addr_prot;
  logic        any_prot;
  logic        prot_allowed;
  logic        launch_ok;
  logic        launch_acc;
  logic        launch_viol;
  logic [7:0]  code;
  logic [1:0]  new_scn;
  logic [1:0]  old_scn;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup    = psel_i && !penable_i;
  assign wr       = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  assign ccf      = (state_q == FCP_IDLE);

  always_comb
  begin
    hit = 1'b1;
    rd_mux = '0;
    unique case (paddr_i)
      fcp_pkg::ADDR_PARAM_INDEX: rd_mux[2:0] = index_q;
      fcp_pkg::ADDR_PARAM_DATA:
        if (index_q <= fcp_pkg::IDX_LAST)
          rd_mux[15:0] = param_q[index_q]; // [R17]
      fcp_pkg::ADDR_STATUS:
      begin
        rd_mux[fcp_pkg::STAT_CCF_BIT]    = ccf;
        rd_mux[fcp_pkg::STAT_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
        rd_mux[fcp_pkg::STAT_PVIOL_BIT]  = pviol_q;
      end
      fcp_pkg::ADDR_CONFIG:    rd_mux[fcp_pkg::CFG_CMD_COMPLETE_IRQ_EN_BIT] = cmd_complete_irq_en_q;
      fcp_pkg::ADDR_SECURITY:  rd_mux[1:0] = sec_q;
      fcp_pkg::ADDR_PROTECTION:
      begin
        rd_mux[fcp_pkg::PROT_OPEN_BIT] = open_q;
        rd_mux[fcp_pkg::PROT_HDIS_BIT] = hdis_q;
        rd_mux[fcp_pkg::PROT_SIZE_HI:fcp_pkg::PROT_SIZE_LO] = size_q;
      end
      fcp_pkg::ADDR_CLOCK_DIV:
      begin
        rd_mux[fcp_pkg::DIV_LOADED_BIT]   = div_loaded_q;
        rd_mux[fcp_pkg::DIV_VALUE_HI:0]   = div_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // Read data and error captured in setup, presented in access
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rdata_q  <= '0;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q  <= pwrite_i ? '0 : rd_mux;
      slverr_q <= !hit;
    end
  end

  assign prdata_o  = rdata_q;
  assign pslverr_o = slverr_q && psel_i && penable_i;

  // ----------------------------------------------------------------
  // Launch checks
  // ----------------------------------------------------------------
  assign code = param_q[fcp_pkg::IDX_CMD_ADDRHI][15:8]; // [R1]
  assign launch_req = wr && (paddr_i == fcp_pkg::ADDR_STATUS) && ccf
                      && pwdata_i[fcp_pkg::STAT_CCF_BIT]; // [R2]

  assign cmd_valid =
    ((code >= fcp_pkg::CMD_FIRST_LO) && (code <= fcp_pkg::CMD_LAST_LO)) ||
    ((code >= fcp_pkg::CMD_FIRST_HI) && (code <= fcp_pkg::CMD_LAST_HI));
    // [R4]
  assign cmd_prog_erase = (code >= fcp_pkg::CMD_PROGRAM) &&
                          (code <= fcp_pkg::CMD_UNSECURE);
  assign cmd_whole = (code == fcp_pkg::CMD_ERASE_ALL) ||
                     (code == fcp_pkg::CMD_ERASE_BLK) ||
                     (code == fcp_pkg::CMD_UNSECURE);

  fcp_prot_check u_prot
  (
    .open_i           (open_q),
    .hdis_i           (hdis_q),
    .size_i           (size_q),
    .addr_i           (param_q[fcp_pkg::IDX_ADDR_LO]),
    .addr_protected_o (addr_prot),
    .any_protected_o  (any_prot)
  );

  assign launch_acc  = !cmd_valid ||                           // [R19]
                       (cmd_prog_erase && !div_loaded_q) ||    // [R18]
                       access_error_flag_q || pviol_q;
  assign launch_viol = !launch_acc && cmd_prog_erase &&
                       (cmd_whole ? any_prot : addr_prot);     // [R20]
  assign launch_ok   = launch_req && !launch_acc && !launch_viol;

  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      state_q <= FCP_INIT;
    else
    begin
      unique case (state_q)
        FCP_INIT: state_q <= FCP_IDLE;
        FCP_IDLE: if (launch_ok) state_q <= FCP_BUSY;   // [R2]
        FCP_BUSY: if (cmd_done_i) state_q <= FCP_IDLE;  // [R3]
        default:  state_q <= FCP_INIT;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      launch_q <= 1'b0;
    else
      launch_q <= launch_ok; // [R2]
  end

  // Error flags: write 1 clears, a new event wins
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      access_error_flag_q <= 1'b0;
      pviol_q  <= 1'b0;
    end
    else
    begin
      if (launch_req && launch_acc)
        access_error_flag_q <= 1'b1; // [R18] [R19]
      else if (wr && paddr_i == fcp_pkg::ADDR_STATUS &&
               pwdata_i[fcp_pkg::STAT_ACCESS_ERROR_FLAG_BIT])
        access_error_flag_q <= 1'b0;
      if (launch_req && launch_viol)
        pviol_q <= 1'b1; // [R20]
      else if (wr && paddr_i == fcp_pkg::ADDR_STATUS &&
               pwdata_i[fcp_pkg::STAT_PVIOL_BIT])
        pviol_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Parameter array and index
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      index_q <= '0;
    else if (wr && ccf && paddr_i == fcp_pkg::ADDR_PARAM_INDEX)
      index_q <= pwdata_i[2:0]; // [R16]
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < fcp_pkg::PARAM_WORDS; i++)
        param_q[i] <= '0;
    end
    else if (state_q == FCP_BUSY && res_we_i &&
             res_index_i <= fcp_pkg::IDX_LAST)
      param_q[res_index_i] <= res_data_i; // [R3]
    else if (wr && ccf && paddr_i == fcp_pkg::ADDR_PARAM_DATA &&
             index_q <= fcp_pkg::IDX_LAST)
      param_q[index_q] <= pwdata_i[15:0]; // [R16] [R17] [R1]
  end

  assign cmd_launch_o = launch_q;
  assign cmd_code_o   = code;
  assign cmd_addr_o   = {param_q[0][7:0], param_q[1]}; // [R1]
  assign cmd_data_o   = {param_q[2], param_q[3], param_q[4], param_q[5]};

  // ----------------------------------------------------------------
  // Configuration, security, divider
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      cmd_complete_irq_en_q <= 1'b0;
    else if (wr && paddr_i == fcp_pkg::ADDR_CONFIG)
      cmd_complete_irq_en_q <= pwdata_i[fcp_pkg::CFG_CMD_COMPLETE_IRQ_EN_BIT];
  end

  assign irq_o = ccf && cmd_complete_irq_en_q; // [R6]

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      sec_q <= fcp_pkg::SEC_RESET;
    else if (state_q == FCP_INIT)
      sec_q <= cfg_sec_byte_i[1:0]; // [R9]
  end

  assign secured_o = (sec_q != 2'b10); // [R5]

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      div_q        <= '0;
      div_loaded_q <= 1'b0;
    end
    else if (wr && paddr_i == fcp_pkg::ADDR_CLOCK_DIV)
    begin
      div_q        <= pwdata_i[fcp_pkg::DIV_VALUE_HI:0];
      div_loaded_q <= 1'b1; // [R18]
    end
  end

  assign clk_div_o = div_q;

  // ----------------------------------------------------------------
  // Protection register: loaded at reset, may only tighten
  // ----------------------------------------------------------------
  assign old_scn = {open_q, hdis_q};
  assign new_scn = {pwdata_i[fcp_pkg::PROT_OPEN_BIT],
                    pwdata_i[fcp_pkg::PROT_HDIS_BIT]};

  always_comb
  begin
    unique case (old_scn)
      fcp_pkg::SCN_NONE:      prot_allowed = 1'b1; // [R14]
      fcp_pkg::SCN_PROT_HIGH: prot_allowed =
        (new_scn == fcp_pkg::SCN_PROT_HIGH) ||
        (new_scn == fcp_pkg::SCN_FULL);            // [R14]
      fcp_pkg::SCN_FULL:      prot_allowed =
        (new_scn == fcp_pkg::SCN_FULL);            // [R14]
      default:                prot_allowed =
        (new_scn == fcp_pkg::SCN_UNPROT_HIGH) ||
        (new_scn == fcp_pkg::SCN_FULL);            // [R14]
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      open_q <= fcp_pkg::PROT_RESET[fcp_pkg::PROT_OPEN_BIT];
      hdis_q <= fcp_pkg::PROT_RESET[fcp_pkg::PROT_HDIS_BIT];
      size_q <= fcp_pkg::PROT_RESET[fcp_pkg::PROT_SIZE_HI:
                                    fcp_pkg::PROT_SIZE_LO];
    end
    else if (state_q == FCP_INIT)
    begin
      open_q <= cfg_prot_byte_i[fcp_pkg::PROT_OPEN_BIT]; // [R8]
      hdis_q <= cfg_prot_byte_i[fcp_pkg::PROT_HDIS_BIT]; // [R8]
      size_q <= cfg_prot_byte_i[fcp_pkg::PROT_SIZE_HI:
                                fcp_pkg::PROT_SIZE_LO];  // [R8]
    end
    else if (wr && paddr_i == fcp_pkg::ADDR_PROTECTION && prot_allowed)
    begin
      open_q <= new_scn[1]; // [R12] [R13]
      hdis_q <= new_scn[0]; // [R12] [R13]
      // Size only while no high region is in force
      if (hdis_q)
        size_q <= pwdata_i[fcp_pkg::PROT_SIZE_HI:fcp_pkg::PROT_SIZE_LO];
    end
  end

endmodule // fcp_top

//--- verif/fcp_top_checker.sv
// Purpose: Port-level assertions for the flash command front end
// Assumes: APB with zero wait states, sync active-high reset
// Notes:   Bound to every instance of the top module

`timescale 1ns/1ps

module fcp_top_checker
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pslverr_o,
  input  wire logic [7:0]  cfg_sec_byte_i,
  input  wire logic        cmd_done_i,
  input  wire logic        cmd_launch_o,
  input  wire logic [7:0]  cmd_code_o,
  input  wire logic        secured_o,
  input  wire logic [5:0]  clk_div_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  logic acc;
  assign acc = psel_i && penable_i;

  property p_launch_cause;
    cmd_launch_o |-> $past(acc && pwrite_i && pwdata_i[7]
      && paddr_i == fcp_pkg::ADDR_STATUS);
  endproperty
  a_launch_cause: assert property (p_launch_cause)
    else $error("launch without a status write");

  property p_launch_pulse;
    cmd_launch_o |=> !cmd_launch_o [*2];
  endproperty
  a_launch_pulse: assert property (p_launch_pulse)
    else $error("launch pulse too long");

  property p_launch_code;
    cmd_launch_o |-> cmd_code_o inside {[8'h01:8'h04], [8'h06:8'h0E]};
  endproperty
  a_launch_code: assert property (p_launch_code)
    else $error("invalid code launched");

  property p_irq_busy;
    cmd_launch_o && !cmd_done_i |=> !irq_o;
  endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("irq while command busy");

  property p_slverr;
    acc |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C,
      8'h10, 8'h14, 8'h18});
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("slave error decode wrong");

  property p_clkdiv;
    acc && pwrite_i && paddr_i == fcp_pkg::ADDR_CLOCK_DIV
      |=> clk_div_o == $past(pwdata_i[5:0]);
  endproperty
  a_clkdiv: assert property (p_clkdiv)
    else $error("divider not taken");

  property p_secured;
    $fell(reset_i) |-> ##3 secured_o == (cfg_sec_byte_i[1:0] != 2'b10);
  endproperty
  a_secured: assert property (p_secured)
    else $error("secure state wrong after reset");

  property p_reset_out;
    $past(reset_i) |-> prdata_o == 32'h0 && !cmd_launch_o && !irq_o;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle after reset");
endmodule // fcp_top_checker

bind fcp_top fcp_top_checker i_fcp_top_checker (
  .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .cfg_sec_byte_i(cfg_sec_byte_i), .cmd_done_i(cmd_done_i),
  .cmd_launch_o(cmd_launch_o), .cmd_code_o(cmd_code_o),
  .secured_o(secured_o), .clk_div_o(clk_div_o), .irq_o(irq_o));

//--- verif/fcp_mem_model.sv
// Purpose: Memory controller stand-in behind the command front end
// Assumes: One command at a time, latency set by the bench
// Notes:   Read-once result word lands at array index 2

`timescale 1ns/1ps

module fcp_mem_model
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       launch_i,
  input  wire logic [7:0] code_i,
  input  wire logic [7:0] delay_i,
  output logic            done_o = 1'b0,
  output logic            res_we_o = 1'b0,
  output logic [2:0]      res_index_o = 3'h0,
  output logic [15:0]     res_data_o = 16'h0
);
  logic [7:0] cnt_q = 8'h00;

  always @(posedge clock_i)
  begin
    done_o <= 1'b0;
    res_we_o <= 1'b0;
    res_data_o <= ~res_data_o;  // No stale data when idle
    if (reset_i)
      cnt_q <= 8'h00;
    else if (launch_i)
    begin
      cnt_q <= delay_i;
      res_we_o <= (code_i == 8'h04);
      res_index_o <= 3'h2;
      res_data_o <= 16'hA5C3;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
      done_o <= (cnt_q == 8'h01);
    end
  end
endmodule // fcp_mem_model

//--- verif/tb_flash_command_and_protection.sv
// Purpose: Self-checking bench for the flash command front end
// Assumes: 20 MHz clock, APB master tasks, controller model
// Notes:   Two resets with different configuration bytes

`timescale 1ns/1ps

module tb_flash_command_and_protection;
  localparam logic [7:0] A_IX = fcp_pkg::ADDR_PARAM_INDEX;
  localparam logic [7:0] A_DT = fcp_pkg::ADDR_PARAM_DATA;
  localparam logic [7:0] A_ST = fcp_pkg::ADDR_STATUS;
  localparam logic [7:0] A_PR = fcp_pkg::ADDR_PROTECTION;
  localparam logic [7:0] A_DV = fcp_pkg::ADDR_CLOCK_DIV;
  typedef struct packed
  {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } fcp_row_s;

  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [7:0]  prot_b = 8'hB8;
  logic [7:0]  sec_b = 8'h00;
  logic [7:0]  dly = 8'h01;
  logic [31:0] prdata_o, r;
  logic        pready_o, pslverr_o, done, res_we, launch_o, secured_o, irq_o;
  logic [2:0]  res_ix;
  logic [15:0] res_d;
  logic [7:0]  code_o, cap_code;
  logic [23:0] addr_o, cap_addr;
  logic [63:0] data_o, cap_data;
  logic [5:0]  div_o;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          launches = 0;
  fcp_row_s    rows [13] = '{
    '{1'b0, A_ST, 32'h0, 32'h80},
    '{1'b0, A_DV, 32'h0, 32'h00},
    '{1'b0, 8'h10, 32'h0, 32'h00},
    '{1'b0, A_PR, 32'h0, 32'hB8},
    '{1'b1, A_PR, 32'h98, 32'h98},
    '{1'b1, A_PR, 32'hA0, 32'h98},
    '{1'b1, A_PR, 32'h18, 32'h98},
    '{1'b1, A_PR, 32'h80, 32'h98},
    '{1'b1, A_IX, 32'h6, 32'h6},
    '{1'b1, A_DT, 32'h1234, 32'h0},
    '{1'b1, 8'h1C, 32'h5A, 32'h0},
    '{1'b1, 8'h0C, 32'h80, 32'h80},
    '{1'b1, A_DV, 32'h13, 32'h93}};

  fcp_top i_fcp_top (.clock_i(clock_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cfg_prot_byte_i(prot_b), .cfg_sec_byte_i(sec_b),
    .cmd_done_i(done), .res_we_i(res_we), .res_index_i(res_ix),
    .res_data_i(res_d), .cmd_launch_o(launch_o), .cmd_code_o(code_o),
    .cmd_addr_o(addr_o), .cmd_data_o(data_o), .secured_o(secured_o),
    .clk_div_o(div_o), .irq_o(irq_o));

  fcp_mem_model i_fcp_mem_model (.clock_i(clock_i), .reset_i(reset_i),
    .launch_i(launch_o), .code_i(code_o), .delay_i(dly), .done_o(done),
    .res_we_o(res_we), .res_index_o(res_ix), .res_data_o(res_d));

  initial
  begin
    forever #25 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
    if (launch_o === 1'b1)
    begin
      launches++;
      cap_code = code_o;
      cap_addr = addr_o;
      cap_data = data_o;
    end

  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      stop_test;
    end
    r = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task wait_idle;
    int i;
    for (i = 0; i < 200; i++)
    begin
      apb(1'b0, A_ST, 32'h0);
      if (r[7] === 1'b1)
        break;
    end
    if (i == 200)
    begin
      bad_count++;
      stop_test;
    end
  endtask

  task issue(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d);
    apb(1'b1, A_IX, 32'h0);
    apb(1'b1, A_DT, {16'h0, c, a[23:16]});
    apb(1'b1, A_IX, 32'h1);
    apb(1'b1, A_DT, {16'h0, a[15:0]});
    apb(1'b1, A_IX, 32'h2);
    apb(1'b1, A_DT, {16'h0, d});
    apb(1'b1, A_ST, 32'h80);
  endtask

  task launch(input logic [7:0] c, input logic [23:0] a, input logic [7:0] e);
    int n0;
    n0 = launches;
    issue(c, a, 16'h0);
    wait_idle;
    chk("status", {24'h0, e}, r);
    chk("launch count", n0 + (e == 8'h80), launches);
    if (e != 8'h80)
    begin
      apb(1'b1, A_ST, {24'h0, e & 8'h30});
      apb(1'b0, A_ST, 32'h0);
      chk("status cleared", 32'h80, r);
    end
  endtask

  task sweep(input logic prot);
    logic [7:0] e;
    for (int k = 0; k < 16; k++)
    begin
      e = !(k inside {[1:4], [6:14]}) ? 8'hA0 :
          (prot && k inside {[6:11]}) ? 8'h90 : 8'h80;
      launch(8'(k), 24'h00C000, e);
    end
  endtask

  task do_reset(input logic [7:0] p, input logic [7:0] s);
    prot_b <= p;
    sec_b <= s;
    reset_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  initial
  begin
    repeat (50000) @(posedge clock_i);
    bad_count++;
    stop_test;
  end

  initial
  begin
    do_reset(8'hB8, 8'h00);
    launch(8'h06, 24'h00C000, 8'hA0);
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("row read", rows[i].e, r);
    end
    chk("secured", 32'h1, {31'h0, secured_o});
    sweep(1'b1);
    chk("irq idle", 32'h1, {31'h0, irq_o});
    dly <= 8'd20;
    issue(8'h04, 24'h01FF40, 16'h1357);
    apb(1'b1, A_IX, 32'h5);
    apb(1'b1, A_DT, 32'h1111);
    chk("irq busy", 32'h0, {31'h0, irq_o});
    apb(1'b0, A_ST, 32'h0);
    chk("status busy", 32'h0, r);
    wait_idle;
    chk("irq done", 32'h1, {31'h0, irq_o});
    chk("code out", 32'h04, {24'h0, cap_code});
    chk("addr out", 32'h01FF40, {8'h0, cap_addr});
    chk("data0 out", 32'h1357, {16'h0, cap_data[63:48]});
    apb(1'b0, A_IX, 32'h0);
    chk("index held", 32'h2, r);
    apb(1'b0, A_DT, 32'h0);
    chk("result", 32'hA5C3, r);
    dly <= 8'd1;
    do_reset(8'hA0, 8'h02);
    chk("unsecured", 32'h0, {31'h0, secured_o});
    apb(1'b1, A_DV, 32'h13);
    sweep(1'b0);
    apb(1'b1, A_PR, 32'h00);
    apb(1'b0, A_PR, 32'h0);
    chk("prot 7 to 1", 32'h00, r);
    launch(8'h06, 24'h00F800, 8'h80);
    launch(8'h06, 24'h00F7FE, 8'h90);
    apb(1'b1, A_PR, 32'h80);
    apb(1'b0, A_PR, 32'h0);
    chk("prot 1 to 5", 32'h00, r);
    apb(1'b1, A_PR, 32'h20);
    apb(1'b0, A_PR, 32'h0);
    chk("prot 1 to 3", 32'h20, r);
    launch(8'h0A, 24'h00F800, 8'h90);
    stop_test;
  end
endmodule // tb_flash_command_and_protection
